// File: fscr_consts.svh
// Purpose: Constants of the flash status and configuration register bank
// Assumes: Included by its bare name by the marking area and register design files
// Notes:   Bit positions, reset values, marking area offsets and timing counts
`ifndef FSCR_CONSTS_SVH
`define FSCR_CONSTS_SVH

// ==========================================================================
// Status register one bit positions
`define FSCR_SR_LOCK_BIT     7
`define FSCR_SR_PERR_BIT     6
`define FSCR_SR_EERR_BIT     5
`define FSCR_SR_RANGE_HI     4
`define FSCR_SR_RANGE_LO     2
`define FSCR_SR_WPL_BIT      1
`define FSCR_SR_PEND_BIT     0

// ==========================================================================
// Configuration register one bit positions
`define FSCR_CR_LAT_HI       7
`define FSCR_CR_LAT_LO       6
`define FSCR_CR_ORIGIN_BIT   5
`define FSCR_CR_VOLAT_BIT    3
`define FSCR_CR_SMALL_BIT    2
`define FSCR_CR_QUAD_BIT     1
`define FSCR_CR_FREEZE_BIT   0

// ==========================================================================
// Reset values; non-volatile ones stand in for the stored array contents
`define FSCR_LOCK_INIT       1'h0
`define FSCR_RANGE_NV_INIT   3'h0
`define FSCR_RANGE_VOL_INIT  3'h7
`define FSCR_LAT_INIT        2'h0
`define FSCR_ORIGIN_INIT     1'h0
`define FSCR_VOLAT_INIT      1'h0
`define FSCR_SMALL_INIT      1'h0
`define FSCR_QUAD_INIT       1'h0

// ==========================================================================
// Electronic marking area, offsets from the sector base
`define FSCR_MARK_SIZE_ADDR  9'h180
`define FSCR_MARK_REV_ADDR   9'h181
`define FSCR_MARK_LOT_FIRST  9'h182
`define FSCR_MARK_LOT_LAST   9'h189
`define FSCR_MARK_WAFER_ADDR 9'h18A
`define FSCR_MARK_DIEX_ADDR  9'h18B
`define FSCR_MARK_DIEY_ADDR  9'h18C
`define FSCR_MARK_CLS_FIRST  9'h18D
`define FSCR_MARK_CLS_LAST   9'h193
`define FSCR_MARK_SIZE       8'h14
`define FSCR_MARK_REV        8'h01
`define FSCR_MARK_BLANK      8'hFF

// ==========================================================================
// Timing: busy cycles of a register write
`define FSCR_WRITE_CYCLES    16

`endif

// File: fscr_pkg.sv
// Purpose: Types of the flash status and configuration register bank
// Assumes: Nothing
// Notes:   Constants live in fscr_consts.svh
package fscr_pkg;

  // ========================================================================
  // Commands from the serial front end
  typedef enum logic [2:0] {
    FSCR_CMD_NONE,
    FSCR_CMD_PERMIT_SET,
    FSCR_CMD_PERMIT_CLEAR,
    FSCR_CMD_REG_WRITE,
    FSCR_CMD_PROGRAM,
    FSCR_CMD_ERASE,
    FSCR_CMD_CLEAR_STATUS
  } fscr_cmd_type;

  // ========================================================================
  // Sequencer states
  typedef enum logic [1:0] {
    FSCR_IDLE,
    FSCR_REG_BUSY,
    FSCR_ARRAY_BUSY
  } fscr_state_type;

endpackage

// File: fscr_mark_rom.sv
// Purpose: Read-only electronic marking area of the flash
// Assumes: Address is the offset from the sector base
// Notes:   Combinational; the caller registers the byte
`timescale 1ns/1ps
`include "fscr_consts.svh"

module fscr_mark_rom #(
  parameter logic [63:0] FAB_LOT   = 64'h4C44383732373046,
  parameter logic [7:0]  WAFER     = 8'h01,
  parameter logic [7:0]  DIE_X     = 8'h01,
  parameter logic [7:0]  DIE_Y     = 8'h01,
  parameter logic [55:0] CLASS_LOT = 56'h41413030303030
) (
  input  wire logic [8:0] addr,
  output logic      [7:0] data
);

  logic [8:0] rel;

  // ========================================================================
  // Byte lookup; lot fields are stored first character in the high byte
  always_comb begin
    rel  = 9'h000;
    data = `FSCR_MARK_BLANK;
    if (addr == `FSCR_MARK_SIZE_ADDR) begin
      data = `FSCR_MARK_SIZE;
    end else if (addr == `FSCR_MARK_REV_ADDR) begin
      data = `FSCR_MARK_REV;
    end else if (addr >= `FSCR_MARK_LOT_FIRST && addr <= `FSCR_MARK_LOT_LAST) begin
      rel  = addr - `FSCR_MARK_LOT_FIRST;
      data = FAB_LOT[{3'h7 - rel[2:0], 3'h0} +: 8];
    end else if (addr == `FSCR_MARK_WAFER_ADDR) begin
      data = WAFER;
    end else if (addr == `FSCR_MARK_DIEX_ADDR) begin
      data = DIE_X;
    end else if (addr == `FSCR_MARK_DIEY_ADDR) begin
      data = DIE_Y;
    end else if (addr >= `FSCR_MARK_CLS_FIRST && addr <= `FSCR_MARK_CLS_LAST) begin
      rel  = addr - `FSCR_MARK_CLS_FIRST;
      data = CLASS_LOT[{3'h6 - rel[2:0], 3'h0} +: 8];
    end
  end

endmodule

// File: fscr_regs.sv
// Purpose: Status register one, configuration register one and marking area
// Assumes: Commands come decoded from a serial front end on clk
// Notes:   Non-volatile bits are modelled as flops reset to their stored values
`timescale 1ns/1ps
`include "fscr_consts.svh"

// How it works
// - Lock bit set with protect pin low makes register writes ignored entirely.
// - Register write, program and erase need the write-permit latch set.
// - Only permit-set and permit-clear commands change the write-permit latch.
// - Operation-pending reads one during any operation, zero when idle.
// - Range bits protect sectors; volatile default ones when volatility bit set.
// - Origin bit one protects from low addresses, zero from high addresses.
// - Small-sector bit one places 4-KB sectors on top, zero bottom.
// - Freeze bit locks range, origin and small-sector bits.
// - Two latency bits select read latency cycles, both defaulting zero.
// - Fab lot, wafer, die X and Y bytes readable as unique ID.
module fscr_regs #(
  parameter int          WRITE_CYCLES = `FSCR_WRITE_CYCLES,
  parameter logic [63:0] FAB_LOT      = 64'h4C44383732373046,
  parameter logic [7:0]  WAFER        = 8'h01,
  parameter logic [7:0]  DIE_X        = 8'h01,
  parameter logic [7:0]  DIE_Y        = 8'h01,
  parameter logic [55:0] CLASS_LOT    = 56'h41413030303030
) (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  ce,
  input  wire logic                  write_protect_n,
  input  wire logic                  cmd_valid,
  input  wire fscr_pkg::fscr_cmd_type cmd_code,
  input  wire logic [7:0]            cmd_status_data,
  input  wire logic [7:0]            cmd_config_data,
  input  wire logic                  cmd_config_present,
  input  wire logic                  array_done,
  input  wire logic                  array_fail,
  input  wire logic [8:0]            mark_addr,
  output logic      [7:0]            status_byte,
  output logic      [7:0]            config_byte,
  output logic                       op_start,
  output logic                       op_erase,
  output logic      [1:0]            latency_select,
  output logic                       quad_enable,
  output logic      [2:0]            protect_range,
  output logic                       protect_from_low,
  output logic                       small_sector_top,
  output logic                       regs_frozen,
  output logic      [7:0]            mark_data
);

  localparam logic [7:0] WRITE_LAST = 8'(WRITE_CYCLES - 1);

  // ========================================================================
  // Protect pin synchroniser
  logic wp_meta_q, wp_meta_d;
  logic wp_sync_q, wp_sync_d;

  always_comb begin
    wp_meta_d = ce ? write_protect_n : wp_meta_q;
    wp_sync_d = ce ? wp_meta_q : wp_sync_q;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wp_meta_q <= 1'h1;
      wp_sync_q <= 1'h1;
    end else begin
      wp_meta_q <= wp_meta_d;
      wp_sync_q <= wp_sync_d;
    end
  end

  // ========================================================================
  // Registers and sequencer
  fscr_pkg::fscr_state_type state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic       lock_q, lock_d;
  logic       perr_q, perr_d;
  logic       eerr_q, eerr_d;
  logic [2:0] range_q, range_d;
  logic       wpl_q, wpl_d;
  logic       pend_q, pend_d;
  logic [1:0] lat_q, lat_d;
  logic       origin_q, origin_d;
  logic       volat_q, volat_d;
  logic       small_q, small_d;
  logic       quad_q, quad_d;
  logic       freeze_q, freeze_d;
  logic       start_q, start_d;
  logic       erase_q, erase_d;
  logic       idle_cmd;
  logic       wrr_go;
  logic       wrr_blocked;
  logic       arr_go;

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    lock_d    = lock_q;
    range_d   = range_q;
    wpl_d     = wpl_q;
    lat_d     = lat_q;
    origin_d  = origin_q;
    volat_d   = volat_q;
    small_d   = small_q;
    quad_d    = quad_q;
    freeze_d  = freeze_q;
    erase_d   = erase_q;
    start_d   = 1'h0;
    perr_d    = perr_q;
    eerr_d    = eerr_q;
    idle_cmd    = ce && cmd_valid && state_q == fscr_pkg::FSCR_IDLE;
    wrr_blocked = lock_q && !wp_sync_q;
    wrr_go      = idle_cmd && cmd_code == fscr_pkg::FSCR_CMD_REG_WRITE && wpl_q && !wrr_blocked;
    arr_go      = idle_cmd && wpl_q && (cmd_code == fscr_pkg::FSCR_CMD_PROGRAM ||
                                        cmd_code == fscr_pkg::FSCR_CMD_ERASE);
    if (ce) begin
      if (idle_cmd) begin
        case (cmd_code)
          fscr_pkg::FSCR_CMD_PERMIT_SET: begin
            wpl_d = 1'h1;
          end
          fscr_pkg::FSCR_CMD_PERMIT_CLEAR: begin
            wpl_d = 1'h0;
          end
          fscr_pkg::FSCR_CMD_CLEAR_STATUS: begin
            perr_d = 1'h0;
            eerr_d = 1'h0;
          end
          default: begin
          end
        endcase
      end
      if (wrr_go) begin
        // Latch untouched by the write itself
        lock_d = cmd_status_data[`FSCR_SR_LOCK_BIT];
        if (!freeze_q) begin
          range_d = cmd_status_data[`FSCR_SR_RANGE_HI:`FSCR_SR_RANGE_LO];
        end
        if (cmd_config_present) begin
          lat_d   = cmd_config_data[`FSCR_CR_LAT_HI:`FSCR_CR_LAT_LO];
          quad_d  = cmd_config_data[`FSCR_CR_QUAD_BIT];
          volat_d = volat_q | cmd_config_data[`FSCR_CR_VOLAT_BIT];
          // One-time bits only go from zero to one, and not while frozen
          if (!freeze_q) begin
            origin_d = origin_q | cmd_config_data[`FSCR_CR_ORIGIN_BIT];
            small_d  = small_q | cmd_config_data[`FSCR_CR_SMALL_BIT];
          end
          // Freeze holds until reset once set
          freeze_d = freeze_q | cmd_config_data[`FSCR_CR_FREEZE_BIT];
        end
        cnt_d   = WRITE_LAST;
        state_d = fscr_pkg::FSCR_REG_BUSY;
      end
      if (arr_go) begin
        start_d = 1'h1;
        erase_d = cmd_code == fscr_pkg::FSCR_CMD_ERASE;
        state_d = fscr_pkg::FSCR_ARRAY_BUSY;
      end
      case (state_q)
        fscr_pkg::FSCR_IDLE: begin
        end
        fscr_pkg::FSCR_REG_BUSY: begin
          if (cnt_q == 8'h00) begin
            state_d = fscr_pkg::FSCR_IDLE;
          end else begin
            cnt_d = cnt_q - 8'h01;
          end
        end
        fscr_pkg::FSCR_ARRAY_BUSY: begin
          if (array_done) begin
            state_d = fscr_pkg::FSCR_IDLE;
            if (array_fail && !erase_q) begin
              perr_d = 1'h1;
            end
            if (array_fail && erase_q) begin
              eerr_d = 1'h1;
            end
          end
        end
        default: begin
          state_d = fscr_pkg::FSCR_IDLE;
        end
      endcase
    end
    pend_d = state_d != fscr_pkg::FSCR_IDLE;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q  <= fscr_pkg::FSCR_IDLE;
      cnt_q    <= 8'h00;
      lock_q   <= `FSCR_LOCK_INIT;
      perr_q   <= 1'h0;
      eerr_q   <= 1'h0;
      range_q  <= `FSCR_VOLAT_INIT ? `FSCR_RANGE_VOL_INIT : `FSCR_RANGE_NV_INIT;
      wpl_q    <= 1'h0;
      pend_q   <= 1'h0;
      lat_q    <= `FSCR_LAT_INIT;
      origin_q <= `FSCR_ORIGIN_INIT;
      volat_q  <= `FSCR_VOLAT_INIT;
      small_q  <= `FSCR_SMALL_INIT;
      quad_q   <= `FSCR_QUAD_INIT;
      freeze_q <= 1'h0;
      start_q  <= 1'h0;
      erase_q  <= 1'h0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      lock_q   <= lock_d;
      perr_q   <= perr_d;
      eerr_q   <= eerr_d;
      range_q  <= range_d;
      wpl_q    <= wpl_d;
      pend_q   <= pend_d;
      lat_q    <= lat_d;
      origin_q <= origin_d;
      volat_q  <= volat_d;
      small_q  <= small_d;
      quad_q   <= quad_d;
      freeze_q <= freeze_d;
      start_q  <= start_d;
      erase_q  <= erase_d;
    end
  end

  // ========================================================================
  // Marking area read port
  logic [7:0] rom_byte;
  logic [7:0] mark_q, mark_d;

  fscr_mark_rom #(
    .FAB_LOT   (FAB_LOT),
    .WAFER     (WAFER),
    .DIE_X     (DIE_X),
    .DIE_Y     (DIE_Y),
    .CLASS_LOT (CLASS_LOT)
  ) u_mark (
    .addr (mark_addr),
    .data (rom_byte)
  );

  always_comb begin
    mark_d = ce ? rom_byte : mark_q;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mark_q <= 8'hFF;
    end else begin
      mark_q <= mark_d;
    end
  end

  // ========================================================================
  // Outputs
  assign status_byte      = {lock_q, perr_q, eerr_q, range_q, wpl_q, pend_q};
  assign config_byte      = {lat_q, origin_q, 1'h0, volat_q, small_q, quad_q, freeze_q};
  assign op_start         = start_q;
  assign op_erase         = erase_q;
  assign latency_select   = lat_q;
  assign quad_enable      = quad_q;
  assign protect_range    = range_q;
  assign protect_from_low = origin_q;
  assign small_sector_top = small_q;
  assign regs_frozen      = freeze_q;
  assign mark_data        = mark_q;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence reg_write_seq;
    wrr_go ##1 pend_q;
  endsequence

  sequence blocked_write_seq;
    ce && cmd_valid && cmd_code == fscr_pkg::FSCR_CMD_REG_WRITE && lock_q && !wp_sync_q;
  endsequence

  lock_ignore_write_a: assert property (blocked_write_seq |=> $stable(lock_q) && $stable(range_q) && $stable(lat_q))
    else $error("register write taken while locked with protect pin low");
  permit_needed_a: assert property (ce && cmd_valid && !wpl_q |=> !start_q && $stable(range_q))
    else $error("command taken with write-permit latch clear");
  write_keeps_latch_a: assert property (wrr_go |=> $stable(wpl_q))
    else $error("register write changed write-permit latch");
  pending_busy_a: assert property (pend_q && cnt_q != 8'h00 |=> pend_q)
    else $error("pending bit dropped during register write");
  pending_end_a: assert property (reg_write_seq |-> ##[1:40] !pend_q)
    else $error("register write never finished");
  range_reset_a: assert property (!$past(rstn) |-> range_q == (volat_q ? 3'h7 : `FSCR_RANGE_NV_INIT))
    else $error("range bits did not take their reset default");
  origin_oneway_a: assert property (!$fell(origin_q) && !$fell(small_q))
    else $error("one-time configuration bit cleared");
  freeze_hold_a: assert property (freeze_q && wrr_go |=> $stable(range_q) && $stable(origin_q) && $stable(small_q))
    else $error("frozen bits changed");
  latency_write_a: assert property (wrr_go && cmd_config_present |=> lat_q == $past(cmd_config_data[7:6]))
    else $error("latency code not written");
  quad_write_a: assert property (wrr_go && cmd_config_present |=> quad_enable == $past(cmd_config_data[1]))
    else $error("four-lane enable not written");
  wafer_read_a: assert property (ce && mark_addr == `FSCR_MARK_WAFER_ADDR |=> mark_data == WAFER)
    else $error("wafer byte wrong");
  error_set_a: assert property (ce && state_q == fscr_pkg::FSCR_ARRAY_BUSY && array_done && array_fail
                                |=> (erase_q ? eerr_q : perr_q) && !pend_q)
    else $error("failure did not set its error bit");

endmodule

// File: fscr_host_model.sv
// Purpose: Serial host controller model issuing decoded commands to the bank
// Assumes: Driven from the bench through the send task
// Notes:   Command data lines are scrambled whenever no command is offered
`timescale 1ns/1ps

module fscr_host_model (
  input  wire logic              clk,
  output logic                   cmd_valid,
  output fscr_pkg::fscr_cmd_type cmd_code,
  output logic [7:0]             cmd_status_data,
  output logic [7:0]             cmd_config_data,
  output logic                   cmd_config_present
);
  initial begin
    cmd_valid = 1'h0;
    cmd_code = fscr_pkg::FSCR_CMD_NONE;
    cmd_status_data = 8'hA5;
    cmd_config_data = 8'h5A;
    cmd_config_present = 1'h0;
  end

  // ========================================================================
  // One command: strobe for a single cycle, then drive the inverted values onto the data lines
  task automatic send(input fscr_pkg::fscr_cmd_type code, input logic [7:0] st, input logic [7:0] cf,
                      input logic cfp);
    @(negedge clk);
    cmd_valid = 1'h1;
    cmd_code = code;
    cmd_status_data = st;
    cmd_config_data = cf;
    cmd_config_present = cfp;
    @(negedge clk);
    cmd_valid = 1'h0;
    cmd_code = fscr_pkg::FSCR_CMD_NONE;
    cmd_status_data = ~st;
    cmd_config_data = ~cf;
    cmd_config_present = ~cfp;
  endtask
endmodule

// File: fscr_regs_bench.sv
// Purpose: Self-checking bench of the status and configuration register bank
// Assumes: Commands come from fscr_host_model; array completion is driven here
// Notes:   A short register write time keeps the run brief
`timescale 1ns/1ps

module fscr_regs_bench;
  localparam logic [63:0] LOT = 64'h5445535430313233;
  localparam logic [55:0] CLS = 56'h51525354555657;
  logic                   clk;
  logic                   rstn;
  logic                   ce;
  logic                   write_protect_n;
  logic                   cmd_valid;
  fscr_pkg::fscr_cmd_type cmd_code;
  logic [7:0]             cmd_status_data;
  logic [7:0]             cmd_config_data;
  logic                   cmd_config_present;
  logic                   array_done;
  logic                   array_fail;
  logic [8:0]             mark_addr;
  logic [7:0]             status_byte;
  logic [7:0]             config_byte;
  logic                   op_start;
  logic                   op_erase;
  logic [1:0]             latency_select;
  logic                   quad_enable;
  logic [2:0]             protect_range;
  logic                   protect_from_low;
  logic                   small_sector_top;
  logic                   regs_frozen;
  logic [7:0]             mark_data;
  int                     fails;
  int                     compares;
  int                     cycles;

  fscr_host_model i_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_status_data(cmd_status_data), .cmd_config_data(cmd_config_data),
    .cmd_config_present(cmd_config_present));

  fscr_regs #(.WRITE_CYCLES(2), .FAB_LOT(LOT), .WAFER(8'h17), .DIE_X(8'h0A), .DIE_Y(8'h0F),
    .CLASS_LOT(CLS)) i_dut (.clk(clk), .rstn(rstn), .ce(ce), .write_protect_n(write_protect_n),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_status_data(cmd_status_data),
    .cmd_config_data(cmd_config_data), .cmd_config_present(cmd_config_present),
    .array_done(array_done), .array_fail(array_fail), .mark_addr(mark_addr),
    .status_byte(status_byte), .config_byte(config_byte), .op_start(op_start), .op_erase(op_erase),
    .latency_select(latency_select), .quad_enable(quad_enable), .protect_range(protect_range),
    .protect_from_low(protect_from_low), .small_sector_top(small_sector_top),
    .regs_frozen(regs_frozen), .mark_data(mark_data));

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // ========================================================================
  // Tasks
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_idle;
    for (int i = 0; i < 100 && status_byte[0] !== 1'h0; i++) @(negedge clk);
    chk8({7'h0, status_byte[0]}, 8'h00, "idle");
  endtask

  task automatic finish_array(input logic fail);
    @(negedge clk);
    array_done = 1'h1;
    array_fail = fail;
    @(negedge clk);
    array_done = 1'h0;
    array_fail = 1'h0;
    wait_idle();
  endtask

  task automatic protect_pin(input logic lvl);
    write_protect_n = lvl;
    repeat (3) @(negedge clk);
  endtask

  function automatic logic [7:0] exp_mark(input logic [8:0] a);
    if (a == 9'h180) return 8'h14;
    if (a == 9'h181) return 8'h01;
    if (a >= 9'h182 && a <= 9'h189) return LOT[(9'h189 - a) * 8 +: 8];
    if (a == 9'h18A) return 8'h17;
    if (a == 9'h18B) return 8'h0A;
    if (a == 9'h18C) return 8'h0F;
    if (a >= 9'h18D && a <= 9'h193) return CLS[(9'h193 - a) * 8 +: 8];
    return 8'hFF;
  endfunction

  task automatic mk(input logic [8:0] a);
    @(negedge clk);
    mark_addr = a;
    @(negedge clk);
    chk8(mark_data, exp_mark(a), "mark");
  endtask

  task automatic print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end

  // ========================================================================
  // Tests
  initial begin
    fails = 0;
    compares = 0;
    cycles = 0;
    rstn = 1'h0;
    ce = 1'h1;
    write_protect_n = 1'h1;
    array_done = 1'h0;
    array_fail = 1'h0;
    mark_addr = 9'h000;
    repeat (5) @(negedge clk);
    rstn = 1'h1;
    chk8(status_byte, 8'h00, "status reset");
    chk8(config_byte, 8'h00, "config reset");
    chk8(mark_data, 8'hFF, "mark reset");
    $display("test reset done");
    i_host.send(fscr_pkg::FSCR_CMD_REG_WRITE, 8'h9C, 8'hFF, 1'h1);
    chk8(status_byte, 8'h00, "write without permit");
    i_host.send(fscr_pkg::FSCR_CMD_PROGRAM, 8'h00, 8'h00, 1'h0);
    chk8({op_start, config_byte[6:0]}, 8'h00, "program without permit");
    $display("test refuse done");
    i_host.send(fscr_pkg::FSCR_CMD_PERMIT_SET, 8'h00, 8'h00, 1'h0);
    chk8(status_byte, 8'h02, "permit set");
    i_host.send(fscr_pkg::FSCR_CMD_REG_WRITE, 8'h7C, 8'hE6, 1'h1);
    chk8(status_byte, 8'h1F, "write busy");
    wait_idle();
    chk8(status_byte, 8'h1E, "after write");
    chk8(config_byte, 8'hE6, "config");
    chk8({protect_from_low, small_sector_top, quad_enable, latency_select, protect_range}, 8'hFF,
      "decoded");
    $display("test write done");
    i_host.send(fscr_pkg::FSCR_CMD_PROGRAM, 8'h00, 8'h00, 1'h0);
    chk8({6'h0, op_start, op_erase}, 8'h02, "program start");
    chk8({7'h0, status_byte[0]}, 8'h01, "program busy");
    finish_array(1'h1);
    chk8(status_byte, 8'h5E, "program error");
    i_host.send(fscr_pkg::FSCR_CMD_ERASE, 8'h00, 8'h00, 1'h0);
    chk8({6'h0, op_start, op_erase}, 8'h03, "erase start");
    finish_array(1'h1);
    chk8(status_byte, 8'h7E, "erase error");
    i_host.send(fscr_pkg::FSCR_CMD_CLEAR_STATUS, 8'h00, 8'h00, 1'h0);
    chk8(status_byte, 8'h1E, "errors cleared");
    $display("test array done");
    i_host.send(fscr_pkg::FSCR_CMD_REG_WRITE, 8'h1C, 8'hE7, 1'h1);
    wait_idle();
    chk8({7'h0, regs_frozen}, 8'h01, "frozen");
    i_host.send(fscr_pkg::FSCR_CMD_REG_WRITE, 8'h00, 8'hE6, 1'h1);
    wait_idle();
    chk8({protect_range, config_byte[4:0]}, 8'hE7, "frozen range");
    $display("test freeze done");
    i_host.send(fscr_pkg::FSCR_CMD_REG_WRITE, 8'h9C, 8'hE6, 1'h1);
    wait_idle();
    chk8(status_byte, 8'h9E, "lock set");
    protect_pin(1'h0);
    i_host.send(fscr_pkg::FSCR_CMD_REG_WRITE, 8'h1C, 8'hE6, 1'h1);
    chk8(status_byte, 8'h9E, "locked write");
    protect_pin(1'h1);
    i_host.send(fscr_pkg::FSCR_CMD_REG_WRITE, 8'h1C, 8'hEE, 1'h1);
    wait_idle();
    chk8(status_byte, 8'h1E, "unlocked write");
    chk8(config_byte, 8'hEF, "volatility set");
    $display("test lock done");
    i_host.send(fscr_pkg::FSCR_CMD_PERMIT_CLEAR, 8'h00, 8'h00, 1'h0);
    chk8(status_byte, 8'h1C, "permit clear");
    i_host.send(fscr_pkg::FSCR_CMD_ERASE, 8'h00, 8'h00, 1'h0);
    chk8({op_start, status_byte[6:0]}, 8'h1C, "erase refused");
    ce = 1'h0;
    i_host.send(fscr_pkg::FSCR_CMD_PERMIT_SET, 8'h00, 8'h00, 1'h0);
    ce = 1'h1;
    chk8(status_byte, 8'h1C, "held by ce");
    $display("test permit done");
    for (int i = 'h17F; i <= 'h195; i++) mk(9'(i));
    mk(9'h000);
    $display("test marking done");
    print_verdict();
  end
endmodule
